// >>> include/opdec_pkg.sv
/*
 opdec_pkg: shared constants and types for the one-byte opcode decoder.
 assumes: opcodes are presented as plain bytes by fetch logic on clk_sys.
*/
// Functional notes
// - register field: B 000, C 001, D 010, E 011, H 100, L 101, A 111, 110 memory
// - 01 dest src is a register move; 110 fields mean memory store or load
// - 00 dest 110 is move immediate with one data byte; 110 targets memory
// - 00 rp 0001 loads a pair with a two-byte immediate word
// - report following byte count: one for byte data, two for word or address
// - 10 op src is accumulator arithmetic or logic with eight op codes
// - 11 op 110 applies the same eight operations to one immediate byte
// - 00 r 100 increments, 00 r 101 decrements a register; 110 is memory
// - pair increment 0011, decrement 1011, add to HL 1001; pair 11 is stack pointer
// - 11 cc 000 conditional return; 11001001 returns always, no operands
// - conditional call and return have two execution lengths by condition
// - 11 rp 0101 push, 11 rp 0001 pop; pair 11 is accumulator and flags
// - 11011011 port input, 11010011 port output, each with one port byte
// - 07 0F 17 1F rotate left, right, left through carry, right through carry
// - 27 2F 37 3F decimal adjust, complement, set carry, complement carry
// - FB enable, F3 disable interrupts, 00 no operation, 76 halt over move
// - EB swap DE HL, E3 swap stack top HL, F9 HL to SP, E9 HL to PC
package opdec_pkg;
	typedef enum logic [5:0] {
		OP_UNDEF, OP_NOP, OP_HALT, OP_REG_MOVE, OP_MOVE_IMM, OP_LOAD_PAIR_IMM,
		OP_ALU_REG, OP_ALU_IMM, OP_REG_INC, OP_REG_DEC, OP_PAIR_INC, OP_PAIR_DEC,
		OP_PAIR_ADD_HL, OP_JUMP, OP_CALL, OP_RETURN, OP_RESTART, OP_PUSH, OP_POP,
		OP_PORT_IN, OP_PORT_OUT, OP_ROT_LEFT, OP_ROT_RIGHT, OP_ROT_LEFT_CY,
		OP_ROT_RIGHT_CY, OP_DECIMAL_ADJUST, OP_CPL_ACC, OP_SET_CARRY, OP_CPL_CARRY,
		OP_INT_ENABLE, OP_INT_DISABLE, OP_READ_INT_MASKS, OP_SET_INT_MASKS,
		OP_STORE_ACC_DIRECT, OP_LOAD_ACC_DIRECT, OP_STORE_HL_DIRECT, OP_LOAD_HL_DIRECT,
		OP_STORE_ACC_INDIRECT, OP_LOAD_ACC_INDIRECT, OP_SWAP_DE_HL,
		OP_SWAP_STACKTOP_HL, OP_HL_TO_STACK_PTR, OP_HL_TO_PROG_COUNTER
	} op_class_t;
	typedef enum logic [1:0] {LEN_NONE, LEN_IMM_BYTE, LEN_IMM_WORD, LEN_ADDR} operand_len_t;
	localparam logic [2:0] REG_B = 3'h0;
	localparam logic [2:0] REG_C = 3'h1;
	localparam logic [2:0] REG_D = 3'h2;
	localparam logic [2:0] REG_E = 3'h3;
	localparam logic [2:0] REG_H = 3'h4;
	localparam logic [2:0] REG_L = 3'h5;
	localparam logic [2:0] REG_MEM = 3'h6;
	localparam logic [2:0] REG_A = 3'h7;
	localparam logic [1:0] PAIR_SP_OR_PSW = 2'h3;
	localparam logic [7:0] OPC_NOP = 8'h00;
	localparam logic [7:0] OPC_HALT = 8'h76;
	localparam logic [7:0] OPC_JUMP = 8'hC3;
	localparam logic [7:0] OPC_CALL = 8'hCD;
	localparam logic [7:0] OPC_RET = 8'hC9;
	localparam logic [7:0] OPC_PORT_IN = 8'hDB;
	localparam logic [7:0] OPC_PORT_OUT = 8'hD3;
	localparam logic [7:0] OPC_ROT_LEFT = 8'h07;
	localparam logic [7:0] OPC_ROT_RIGHT = 8'h0F;
	localparam logic [7:0] OPC_ROT_LEFT_CY = 8'h17;
	localparam logic [7:0] OPC_ROT_RIGHT_CY = 8'h1F;
	localparam logic [7:0] OPC_DEC_ADJ = 8'h27;
	localparam logic [7:0] OPC_CPL_ACC = 8'h2F;
	localparam logic [7:0] OPC_SET_CARRY = 8'h37;
	localparam logic [7:0] OPC_CPL_CARRY = 8'h3F;
	localparam logic [7:0] OPC_INT_EN = 8'hFB;
	localparam logic [7:0] OPC_INT_DIS = 8'hF3;
	localparam logic [7:0] OPC_READ_MASKS = 8'h20;
	localparam logic [7:0] OPC_SET_MASKS = 8'h30;
	localparam logic [7:0] OPC_STA = 8'h32;
	localparam logic [7:0] OPC_LDA = 8'h3A;
	localparam logic [7:0] OPC_SHL = 8'h22;
	localparam logic [7:0] OPC_LHL = 8'h2A;
	localparam logic [7:0] OPC_SWAP_DE_HL = 8'hEB;
	localparam logic [7:0] OPC_SWAP_ST_HL = 8'hE3;
	localparam logic [7:0] OPC_HL_TO_SP = 8'hF9;
	localparam logic [7:0] OPC_HL_TO_PC = 8'hE9;
	localparam logic [2:0] COND_ALWAYS_CODE = 3'h0;
	localparam int RESTART_STRIDE_SHIFT = 3;
endpackage

// >>> include/opdec_if.sv
/*
 opdec_if: decoded fields passed from the combinational core to the register stage.
 assumes: both ends sit on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
interface opdec_if;
	import opdec_pkg::*;
	op_class_t opClass;
	operand_len_t operandLen;
	logic [2:0] destField;
	logic [2:0] srcField;
	logic [1:0] pairField;
	logic [2:0] aluOp;
	logic [2:0] condCode;
	logic isConditional;
	logic twoLengths;
	logic [7:0] restartAddr;
	logic undefinedOp;
	logic destIsMem;
	logic srcIsMem;
	logic pairIsAccFlags;
	modport core (output opClass, operandLen, destField, srcField, pairField, aluOp,
		condCode, isConditional, twoLengths, restartAddr, undefinedOp, destIsMem, srcIsMem,
		pairIsAccFlags);
	modport stage (input opClass, operandLen, destField, srcField, pairField, aluOp,
		condCode, isConditional, twoLengths, restartAddr, undefinedOp, destIsMem, srcIsMem,
		pairIsAccFlags);
endinterface
`default_nettype wire

// >>> hw/opdec_core.sv
/*
 opdec_core: purely combinational classification of one opcode byte.
 assumes: the byte is stable for the cycle; results are registered by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module opdec_core (
	// opcode in
	input wire logic [7:0] opcode,
	// decoded fields out
	opdec_if.core dec
);
	import opdec_pkg::*;
	wire logic [1:0] grp = opcode[7:6];
	wire logic [2:0] mid = opcode[5:3];
	wire logic [2:0] low = opcode[2:0];
	wire logic [3:0] nib = opcode[3:0];
	always_comb begin
		dec.opClass = OP_UNDEF;
		dec.operandLen = LEN_NONE;
		dec.isConditional = 1'b0;
		if (opcode == OPC_HALT) begin
			dec.opClass = OP_HALT; // halt beats the move pattern
		end else if (grp == 2'h1) begin
			dec.opClass = OP_REG_MOVE;
		end else if (grp == 2'h2) begin
			dec.opClass = OP_ALU_REG;
		end else if (grp == 2'h0) begin
			if (opcode == OPC_NOP) dec.opClass = OP_NOP;
			else if (opcode == OPC_ROT_LEFT) dec.opClass = OP_ROT_LEFT;
			else if (opcode == OPC_ROT_RIGHT) dec.opClass = OP_ROT_RIGHT;
			else if (opcode == OPC_ROT_LEFT_CY) dec.opClass = OP_ROT_LEFT_CY;
			else if (opcode == OPC_ROT_RIGHT_CY) dec.opClass = OP_ROT_RIGHT_CY;
			else if (opcode == OPC_DEC_ADJ) dec.opClass = OP_DECIMAL_ADJUST;
			else if (opcode == OPC_CPL_ACC) dec.opClass = OP_CPL_ACC;
			else if (opcode == OPC_SET_CARRY) dec.opClass = OP_SET_CARRY;
			else if (opcode == OPC_CPL_CARRY) dec.opClass = OP_CPL_CARRY;
			else if (opcode == OPC_READ_MASKS) dec.opClass = OP_READ_INT_MASKS;
			else if (opcode == OPC_SET_MASKS) dec.opClass = OP_SET_INT_MASKS;
			else if (opcode == OPC_STA) begin
				dec.opClass = OP_STORE_ACC_DIRECT;
				dec.operandLen = LEN_ADDR;
			end else if (opcode == OPC_LDA) begin
				dec.opClass = OP_LOAD_ACC_DIRECT;
				dec.operandLen = LEN_ADDR;
			end else if (opcode == OPC_SHL) begin
				dec.opClass = OP_STORE_HL_DIRECT;
				dec.operandLen = LEN_ADDR;
			end else if (opcode == OPC_LHL) begin
				dec.opClass = OP_LOAD_HL_DIRECT;
				dec.operandLen = LEN_ADDR;
			end else if (low == 3'h6) begin
				dec.opClass = OP_MOVE_IMM;
				dec.operandLen = LEN_IMM_BYTE;
			end else if (low == 3'h4) dec.opClass = OP_REG_INC;
			else if (low == 3'h5) dec.opClass = OP_REG_DEC;
			else if (nib == 4'h1) begin
				dec.opClass = OP_LOAD_PAIR_IMM;
				dec.operandLen = LEN_IMM_WORD;
			end else if (nib == 4'h3) dec.opClass = OP_PAIR_INC;
			else if (nib == 4'hB) dec.opClass = OP_PAIR_DEC;
			else if (nib == 4'h9) dec.opClass = OP_PAIR_ADD_HL;
			else if (nib == 4'h2 && !opcode[5]) dec.opClass = OP_STORE_ACC_INDIRECT;
			else if (nib == 4'hA && !opcode[5]) dec.opClass = OP_LOAD_ACC_INDIRECT;
		end else begin
			if (opcode == OPC_JUMP) begin
				dec.opClass = OP_JUMP;
				dec.operandLen = LEN_ADDR;
			end else if (opcode == OPC_CALL) begin
				dec.opClass = OP_CALL;
				dec.operandLen = LEN_ADDR;
			end else if (opcode == OPC_RET) dec.opClass = OP_RETURN;
			else if (opcode == OPC_PORT_IN) begin
				dec.opClass = OP_PORT_IN;
				dec.operandLen = LEN_IMM_BYTE;
			end else if (opcode == OPC_PORT_OUT) begin
				dec.opClass = OP_PORT_OUT;
				dec.operandLen = LEN_IMM_BYTE;
			end else if (opcode == OPC_INT_EN) dec.opClass = OP_INT_ENABLE;
			else if (opcode == OPC_INT_DIS) dec.opClass = OP_INT_DISABLE;
			else if (opcode == OPC_SWAP_DE_HL) dec.opClass = OP_SWAP_DE_HL;
			else if (opcode == OPC_SWAP_ST_HL) dec.opClass = OP_SWAP_STACKTOP_HL;
			else if (opcode == OPC_HL_TO_SP) dec.opClass = OP_HL_TO_STACK_PTR;
			else if (opcode == OPC_HL_TO_PC) dec.opClass = OP_HL_TO_PROG_COUNTER;
			else if (low == 3'h0) begin
				dec.opClass = OP_RETURN;
				dec.isConditional = 1'b1;
			end else if (low == 3'h2) begin
				dec.opClass = OP_JUMP;
				dec.operandLen = LEN_ADDR;
				dec.isConditional = 1'b1;
			end else if (low == 3'h4) begin
				dec.opClass = OP_CALL;
				dec.operandLen = LEN_ADDR;
				dec.isConditional = 1'b1;
			end else if (low == 3'h6) begin
				dec.opClass = OP_ALU_IMM;
				dec.operandLen = LEN_IMM_BYTE;
			end else if (low == 3'h7) dec.opClass = OP_RESTART;
			else if (nib == 4'h5) dec.opClass = OP_PUSH;
			else if (nib == 4'h1) dec.opClass = OP_POP;
		end
	end
	// fields are always extracted; they only mean something for the matching class
	assign dec.destField = mid;
	assign dec.srcField = low;
	assign dec.pairField = opcode[5:4];
	assign dec.aluOp = mid;
	assign dec.condCode = mid;
	assign dec.undefinedOp = (dec.opClass == OP_UNDEF);
	// only conditional call and return vary in length; conditional jump is left out
	assign dec.twoLengths = dec.isConditional &&
		(dec.opClass == OP_CALL || dec.opClass == OP_RETURN);
	assign dec.restartAddr = {2'h0, mid, 3'h0};
	assign dec.destIsMem = (mid == REG_MEM);
	assign dec.srcIsMem = (low == REG_MEM);
	assign dec.pairIsAccFlags = (opcode[5:4] == PAIR_SP_OR_PSW) &&
		(dec.opClass == OP_PUSH || dec.opClass == OP_POP);
endmodule // opdec_core
`default_nettype wire

// >>> hw/opcode_decoder.sv
/*
 opcode_decoder: registers the decode of one opcode byte per strobe.
 assumes: fetch logic on clk_sys pulses opValid with the byte; result one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module opcode_decoder (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// opcode from fetch
	input wire logic opValid,
	input wire logic [7:0] opcode,
	// decoded result
	output logic decValid_q,
	output opdec_pkg::op_class_t opClass_q,
	output opdec_pkg::operand_len_t operandLen_q,
	output logic [1:0] operandBytes_q,
	output logic [2:0] destField_q,
	output logic [2:0] srcField_q,
	output logic [1:0] pairField_q,
	output logic [2:0] aluOp_q,
	output logic [2:0] condCode_q,
	output logic isConditional_q,
	output logic twoLengths_q,
	output logic [7:0] restartAddr_q,
	output logic undefinedOp_q,
	output logic destIsMem_q,
	output logic srcIsMem_q,
	output logic pairIsAccFlags_q
);
	import opdec_pkg::*;
	opdec_if decBus ();
	opdec_core u_core (
		.opcode(opcode),
		.dec(decBus.core)
	);
	function automatic logic [1:0] len_to_bytes(input operand_len_t len);
		case (len)
			LEN_IMM_BYTE: len_to_bytes = 2'h1;
			LEN_IMM_WORD: len_to_bytes = 2'h2;
			LEN_ADDR: len_to_bytes = 2'h2;
			default: len_to_bytes = 2'h0;
		endcase
	endfunction
	wire logic [1:0] bytesNext = len_to_bytes(decBus.operandLen);
	// decoded outputs hold the last decode until the next strobe; decValid_q follows opValid every cycle
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			decValid_q <= 1'b0;
			opClass_q <= OP_NOP;
			operandLen_q <= LEN_NONE;
			operandBytes_q <= 2'h0;
			destField_q <= 3'h0;
			srcField_q <= 3'h0;
			pairField_q <= 2'h0;
			aluOp_q <= 3'h0;
			condCode_q <= 3'h0;
			isConditional_q <= 1'b0;
			twoLengths_q <= 1'b0;
			restartAddr_q <= 8'h00;
			undefinedOp_q <= 1'b0;
			destIsMem_q <= 1'b0;
			srcIsMem_q <= 1'b0;
			pairIsAccFlags_q <= 1'b0;
		end else begin
			decValid_q <= opValid;
			if (opValid) begin
				opClass_q <= decBus.opClass;
				operandLen_q <= decBus.operandLen;
				operandBytes_q <= bytesNext;
				destField_q <= decBus.destField;
				srcField_q <= decBus.srcField;
				pairField_q <= decBus.pairField;
				aluOp_q <= decBus.aluOp;
				condCode_q <= decBus.condCode;
				isConditional_q <= decBus.isConditional;
				twoLengths_q <= decBus.twoLengths;
				restartAddr_q <= decBus.restartAddr;
				undefinedOp_q <= decBus.undefinedOp;
				destIsMem_q <= decBus.destIsMem;
				srcIsMem_q <= decBus.srcIsMem;
				pairIsAccFlags_q <= decBus.pairIsAccFlags;
			end
		end
	end
endmodule // opcode_decoder
`default_nettype wire

// >>> testbench/opcode_fetch_model.sv
/* opcode_fetch_model: fetch side that hands opcode bytes to the decoder.
 assumes: the bench holds fetchByte while it asks; one byte a cycle. */
`timescale 1ns/1ps
`default_nettype none
module opcode_fetch_model (
	// request from bench
	input wire logic fetchReq,
	input wire logic [7:0] fetchByte,
	// toward the decoder
	output logic opValid,
	output logic [7:0] opcode
);
	assign opValid = fetchReq;
	// released bus shows the inverse so a stale byte can never pass
	assign opcode = fetchReq ? fetchByte : ~fetchByte;
endmodule // opcode_fetch_model
`default_nettype wire

// >>> testbench/opcode_decoder_assertions.sv
/* opcode_decoder_assertions: port checks on the registered decoder.
 assumes: bound to opcode_decoder, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module opcode_decoder_assertions (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// request
	input wire logic opValid,
	input wire logic [7:0] opcode,
	// result
	input wire logic decValid_q,
	input wire opdec_pkg::op_class_t opClass_q,
	input wire opdec_pkg::operand_len_t operandLen_q,
	input wire logic [1:0] operandBytes_q,
	input wire logic [2:0] destField_q,
	input wire logic [2:0] srcField_q,
	input wire logic isConditional_q,
	input wire logic twoLengths_q,
	input wire logic [7:0] restartAddr_q,
	input wire logic undefinedOp_q,
	input wire logic destIsMem_q
);
	import opdec_pkg::*;
	logic [7:0] opPrev_q;
	always_ff @(posedge clk_sys) opPrev_q <= opcode;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence taken_s;
		opValid ##1 decValid_q;
	endsequence
	result_pulse_a: assert property (opValid |=> decValid_q) else $error("no result pulse");
	no_spurious_a: assert property (!opValid |=> !decValid_q && $stable(opClass_q))
		else $error("result without opcode");
	fields_follow_a: assert property (taken_s |-> destField_q == opPrev_q[5:3]
		&& srcField_q == opPrev_q[2:0]) else $error("fields wrong");
	restart_addr_a: assert property (taken_s |-> restartAddr_q == {2'h0, opPrev_q[5:3], 3'h0})
		else $error("restart address wrong");
	halt_first_a: assert property (opValid && opcode == 8'h76 |=> opClass_q == OP_HALT)
		else $error("halt not decoded");
	undef_flag_a: assert property (decValid_q |-> undefinedOp_q == (opClass_q == OP_UNDEF))
		else $error("undefined flag wrong");
	len_bytes_a: assert property (decValid_q |-> operandBytes_q ==
		(operandLen_q == LEN_NONE ? 2'h0 : operandLen_q == LEN_IMM_BYTE ? 2'h1 : 2'h2))
		else $error("byte count wrong");
	two_lengths_a: assert property (decValid_q |-> twoLengths_q ==
		(isConditional_q && opClass_q inside {OP_CALL, OP_RETURN})) else $error("two lengths wrong");
	mem_dest_a: assert property (taken_s |-> destIsMem_q == (opPrev_q[5:3] == 3'h6))
		else $error("memory flag wrong");
endmodule // opcode_decoder_assertions
bind opcode_decoder opcode_decoder_assertions chk (.clk_sys, .sys_rst, .opValid, .opcode,
	.decValid_q, .opClass_q, .operandLen_q, .operandBytes_q, .destField_q, .srcField_q,
	.isConditional_q, .twoLengths_q, .restartAddr_q, .undefinedOp_q, .destIsMem_q);
`default_nettype wire

// >>> testbench/opcode_decoder_tb_top.sv
/* opcode_decoder_tb_top: self-checking bench for the opcode decoder.
 assumes: fetch model in front; bytes issued back to back at falling edges. */
`timescale 1ns/1ps
`default_nettype none
module opcode_decoder_tb_top;
	import opdec_pkg::*;
	logic clk_sys, sys_rst, fetchReq, opValid, decValid_q, isConditional_q, twoLengths_q;
	logic undefinedOp_q, destIsMem_q, srcIsMem_q, pairIsAccFlags_q;
	logic [7:0] fetchByte, opcode, restartAddr_q;
	logic [2:0] destField_q, srcField_q, aluOp_q, condCode_q;
	logic [1:0] pairField_q, operandBytes_q;
	op_class_t opClass_q;
	operand_len_t operandLen_q;
	int errors = 0, n_compared = 0, cycles = 0;
	opcode_fetch_model fetch (.fetchReq, .fetchByte, .opValid, .opcode);
	opcode_decoder dut (.clk_sys, .sys_rst, .opValid, .opcode, .decValid_q, .opClass_q,
		.operandLen_q, .operandBytes_q, .destField_q, .srcField_q, .pairField_q, .aluOp_q,
		.condCode_q, .isConditional_q, .twoLengths_q, .restartAddr_q, .undefinedOp_q,
		.destIsMem_q, .srcIsMem_q, .pairIsAccFlags_q);
	task automatic wrap_up;
		if (errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic dec(logic [7:0] op, op_class_t cls, logic [1:0] nb);
		@(negedge clk_sys);
		fetchReq = 1'b1;
		fetchByte = op;
		@(posedge clk_sys);
		#1;
		chk("valid", 8'h01, {7'h0, decValid_q});
		chk("class", {2'h0, cls}, {2'h0, opClass_q});
		chk("bytes", {6'h0, nb}, {6'h0, operandBytes_q});
	endtask
	task automatic t_moves;
		dec(8'h41, OP_REG_MOVE, 2'h0);
		chk("src", 8'h01, {5'h0, srcField_q});
		dec(8'h70, OP_REG_MOVE, 2'h0);
		chk("dmem", 8'h01, {7'h0, destIsMem_q});
		dec(8'h7E, OP_REG_MOVE, 2'h0);
		chk("smem", 8'h01, {7'h0, srcIsMem_q});
		chk("dest", 8'h07, {5'h0, destField_q});
		dec(8'h76, OP_HALT, 2'h0);
	endtask
	task automatic t_imm;
		logic [7:0] ops [12] = '{8'h06, 8'h36, 8'h01, 8'h31, 8'hC6, 8'hFE, 8'hDB, 8'hD3,
			8'h32, 8'h3A, 8'h22, 8'h2A};
		op_class_t cls [12] = '{OP_MOVE_IMM, OP_MOVE_IMM, OP_LOAD_PAIR_IMM, OP_LOAD_PAIR_IMM,
			OP_ALU_IMM, OP_ALU_IMM, OP_PORT_IN, OP_PORT_OUT, OP_STORE_ACC_DIRECT,
			OP_LOAD_ACC_DIRECT, OP_STORE_HL_DIRECT, OP_LOAD_HL_DIRECT};
		operand_len_t lens [12] = '{LEN_IMM_BYTE, LEN_IMM_BYTE, LEN_IMM_WORD, LEN_IMM_WORD,
			LEN_IMM_BYTE, LEN_IMM_BYTE, LEN_IMM_BYTE, LEN_IMM_BYTE, LEN_ADDR, LEN_ADDR,
			LEN_ADDR, LEN_ADDR};
		for (int i = 0; i < 12; i++) begin
			dec(ops[i], cls[i], (i inside {2, 3} || i > 7) ? 2'h2 : 2'h1);
			chk("len", {6'h0, lens[i]}, {6'h0, operandLen_q});
		end
	endtask
	task automatic t_groups;
		logic [7:0] ops3 [3] = '{8'hC3, 8'hCD, 8'hC9};
		op_class_t cls3 [3] = '{OP_JUMP, OP_CALL, OP_RETURN};
		logic [1:0] nb3 [3] = '{2'h2, 2'h2, 2'h0};
		for (int i = 0; i < 8; i++) begin
			dec({2'h2, i[2:0], 3'h2}, OP_ALU_REG, 2'h0);
			chk("aluop", i[7:0], {5'h0, aluOp_q});
			dec({2'h3, i[2:0], 3'h6}, OP_ALU_IMM, 2'h1);
			chk("aluop", i[7:0], {5'h0, aluOp_q});
			dec({2'h3, i[2:0], 3'h2}, OP_JUMP, 2'h2);
			chk("cond", {7'h0, 1'b1}, {7'h0, isConditional_q});
			chk("ccode", i[7:0], {5'h0, condCode_q});
			chk("two", 8'h00, {7'h0, twoLengths_q});
			dec({2'h3, i[2:0], 3'h4}, OP_CALL, 2'h2);
			chk("two", 8'h01, {7'h0, twoLengths_q});
			dec({2'h3, i[2:0], 3'h0}, OP_RETURN, 2'h0);
			chk("two", 8'h01, {7'h0, twoLengths_q});
			dec({2'h3, i[2:0], 3'h7}, OP_RESTART, 2'h0);
			chk("rst", {2'h0, i[2:0], 3'h0}, restartAddr_q);
			dec({2'h0, i[2:0], 3'h4}, OP_REG_INC, 2'h0);
			dec({2'h0, i[2:0], 3'h5}, OP_REG_DEC, 2'h0);
			chk("dmem", {7'h0, i == 6}, {7'h0, destIsMem_q});
		end
		foreach (ops3[j]) begin
			dec(ops3[j], cls3[j], nb3[j]);
			chk("uncond", 8'h00, {7'h0, isConditional_q});
		end
	endtask
	task automatic t_pairs;
		for (int p = 0; p < 4; p++) begin
			dec({2'h0, p[1:0], 4'h3}, OP_PAIR_INC, 2'h0);
			dec({2'h0, p[1:0], 4'hB}, OP_PAIR_DEC, 2'h0);
			dec({2'h0, p[1:0], 4'h9}, OP_PAIR_ADD_HL, 2'h0);
			chk("pair", p[7:0], {6'h0, pairField_q});
			dec({2'h3, p[1:0], 4'h5}, OP_PUSH, 2'h0);
			dec({2'h3, p[1:0], 4'h1}, OP_POP, 2'h0);
			chk("accfl", {7'h0, p == 3}, {7'h0, pairIsAccFlags_q});
		end
	endtask
	task automatic t_fixed;
		logic [7:0] ops [17] = '{8'h07, 8'h0F, 8'h17, 8'h1F, 8'h27, 8'h2F, 8'h37, 8'h3F,
			8'hFB, 8'hF3, 8'h00, 8'h20, 8'h30, 8'hEB, 8'hE3, 8'hF9, 8'hE9};
		op_class_t cls [17] = '{OP_ROT_LEFT, OP_ROT_RIGHT, OP_ROT_LEFT_CY, OP_ROT_RIGHT_CY,
			OP_DECIMAL_ADJUST, OP_CPL_ACC, OP_SET_CARRY, OP_CPL_CARRY, OP_INT_ENABLE,
			OP_INT_DISABLE, OP_NOP, OP_READ_INT_MASKS, OP_SET_INT_MASKS, OP_SWAP_DE_HL,
			OP_SWAP_STACKTOP_HL, OP_HL_TO_STACK_PTR, OP_HL_TO_PROG_COUNTER};
		logic [7:0] und [10] = '{8'h08, 8'h10, 8'h18, 8'h28, 8'h38, 8'hCB, 8'hD9, 8'hDD,
			8'hED, 8'hFD};
		for (int i = 0; i < 17; i++)
			dec(ops[i], cls[i], 2'h0);
		for (int i = 0; i < 10; i++) begin
			dec(und[i], OP_UNDEF, 2'h0);
			chk("undef", 8'h01, {7'h0, undefinedOp_q});
		end
		dec(8'h02, OP_STORE_ACC_INDIRECT, 2'h0);
		chk("undef", 8'h00, {7'h0, undefinedOp_q});
		dec(8'h1A, OP_LOAD_ACC_INDIRECT, 2'h0);
		dec(8'hC3, OP_JUMP, 2'h2);
		chk("uncond", 8'h00, {7'h0, isConditional_q});
		dec(8'hCD, OP_CALL, 2'h2);
		dec(8'hC9, OP_RETURN, 2'h0);
		chk("two", 8'h00, {7'h0, twoLengths_q});
	endtask
	// mid-run reset: valid, class, byte count and restart address must read their reset values after the next rising edge
	task automatic t_reset;
		@(negedge clk_sys);
		fetchReq = 1'b0;
		sys_rst = 1'b1;
		@(posedge clk_sys);
		#1;
		chk("rstvalid", 8'h00, {7'h0, decValid_q});
		chk("rstclass", {2'h0, OP_NOP}, {2'h0, opClass_q});
		chk("rstbytes", 8'h00, {6'h0, operandBytes_q});
		chk("rstaddr", 8'h00, restartAddr_q);
		@(negedge clk_sys);
		sys_rst = 1'b0;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			wrap_up();
		end
	end
	initial begin
		sys_rst = 1'b1;
		fetchReq = 1'b0;
		fetchByte = 8'h00;
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys);
		sys_rst = 1'b0;
		chk("rstclass", {2'h0, OP_NOP}, {2'h0, opClass_q});
		t_moves();
		t_imm();
		t_groups();
		t_reset();
		t_pairs();
		t_fixed();
		@(negedge clk_sys);
		fetchReq = 1'b0;
		@(posedge clk_sys);
		#1;
		chk("idle", 8'h00, {7'h0, decValid_q});
		chk("held", {2'h0, OP_RETURN}, {2'h0, opClass_q});
		wrap_up();
	end
endmodule // opcode_decoder_tb_top
`default_nettype wire
